// [rtl/phy_ctl.sv]
// What this block does
// - first ALIGN after power-on goes out at the fastest supported rate
// - ALIGN only at a valid rate, never while the rate is changing
// - after the wake burst ends the transmitter sends ALIGN, going quiet only if the ALIGN wait times out
// - host ALIGN ignored during the early idle window to reject crosstalk
// - ALIGN wait may be stretched by 54.6us, at most 109.2us in total
// - no idle gap between the end of the wake burst and the first ALIGN
// - a device-initiated wake resumes at the earlier negotiated rate
// - a failed device-initiated wake never lowers the rate
// - a failed device-initiated wake retries the wake burst
// - partial request in ready moves to light sleep
// - slumber request without partial request in ready moves to deep sleep
// - without power requests stay ready and send every link-layer word
// - ready flag only while in ready and receiver is in sync
// - light sleep is quiet; request drop without host wake starts own wake burst
// - request drop with host wake seen goes to await wake end
// - send ALIGN until host ALIGN or the timeout; host ALIGN means ready
`include "phy_ctl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module phy_ctl #(
    parameter int ALIGN_WAIT_CYC = `ALIGN_WAIT_NS / `CLK_NS,
    parameter int ALIGN_EXT_CYC = `ALIGN_EXT_NS / `CLK_NS
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire phy_ctl_pkg::rx_status_s rx,
    input wire logic tx_ready,
    output var phy_ctl_pkg::tx_out_s tx,
    input wire logic partial_req,
    input wire logic slumber_req,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic [31:0] word_data,
    output logic phy_rdy,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import phy_ctl_pkg::*;

    localparam int XTALK_CYC = (`XTALK_NS + `CLK_NS - 1) / `CLK_NS;

    phy_state_e state_q;
    phy_state_e state_d;
    rate_t rate_q;
    rate_t neg_rate_q;
    logic resume_q;
    logic ext_en_q;
    logic [7:0] guard_q;
    logic guard_done;
    logic align_ok;
    logic tmr_load;
    logic [`TMR_W-1:0] tmr_val;
    logic tmr_done;
    logic fifo_valid;
    logic fifo_pop;
    logic [31:0] fifo_data;
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // one reusable timer: wake burst length, ALIGN wait, rate settle
    cycle_timer #(.W(`TMR_W)) u_tmr (
        .mclk(mclk),
        .rstn(rstn),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // link-layer words wait here; back-pressure reaches the link layer
    word_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(word_valid),
        .in_ready(word_ready),
        .in_data(word_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // early detections may be crosstalk on an idle line
    assign guard_done = (guard_q >= 8'(XTALK_CYC));
    assign align_ok = rx.align_det && guard_done;

    always_comb begin
        state_d = state_q;
        case (state_q)
            listen_state: begin
                if (rx.comwake_det) begin
                    state_d = await_wake_end_state;
                end
            end
            await_wake_end_state: begin
                if (!rx.comwake_det) begin
                    state_d = wake_burst_tx_state;
                end
            end
            wake_burst_tx_state: begin
                if (tmr_done) begin
                    state_d = align_tx_state;
                end
            end
            align_tx_state: begin
                if (align_ok) begin
                    state_d = link_ready_state;
                end else if (tmr_done) begin
                    if (resume_q || rate_q == `RATE_LOWEST) begin
                        state_d = fail_state;
                    end else begin
                        state_d = reduce_speed_state;
                    end
                end
            end
            link_ready_state: begin
                if (partial_req) begin
                    state_d = light_sleep_state;
                end else if (slumber_req) begin
                    state_d = deep_sleep_state;
                end
            end
            light_sleep_state: begin
                if (!partial_req) begin
                    // host wake wins a tie with own wake
                    state_d = rx.comwake_det ? await_wake_end_state
                                             : wake_burst_tx_state;
                end
            end
            deep_sleep_state: begin
                if (!slumber_req) begin
                    state_d = rx.comwake_det ? await_wake_end_state
                                             : wake_burst_tx_state;
                end
            end
            reduce_speed_state: begin
                if (tmr_done) begin
                    state_d = align_tx_state;
                end
            end
            fail_state: begin
                if (resume_q) begin
                    state_d = wake_burst_tx_state;
                end else if (rx.comwake_det) begin
                    state_d = await_wake_end_state;
                end
            end
            default: state_d = listen_state;
        endcase
    end

    always_comb begin
        tmr_load = (state_d != state_q);
        case (state_d)
            wake_burst_tx_state: tmr_val = `WAKE_BURST_CYC;
            align_tx_state: tmr_val = ext_en_q ? `TMR_W'(ALIGN_WAIT_CYC + ALIGN_EXT_CYC)
                                               : `TMR_W'(ALIGN_WAIT_CYC);
            reduce_speed_state: tmr_val = `RATE_SETTLE_CYC;
            default: tmr_val = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= listen_state;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            guard_q <= '0;
        end else if (state_q != align_tx_state) begin
            guard_q <= '0;
        end else if (!guard_done) begin
            guard_q <= guard_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            resume_q <= 1'b0;
        end else if (state_d == light_sleep_state || state_d == deep_sleep_state) begin
            resume_q <= 1'b1;
        end else if (state_d == link_ready_state || state_d == listen_state) begin
            resume_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rate_q <= `RATE_FASTEST;
            neg_rate_q <= `RATE_FASTEST;
        end else begin
            if (state_q == align_tx_state && state_d == link_ready_state && !resume_q) begin
                neg_rate_q <= rate_q;
            end
            if (state_d == reduce_speed_state && state_q != reduce_speed_state) begin
                rate_q <= rate_q - 2'h1;
            end else if (resume_q && state_q != state_d
                         && (state_d == wake_burst_tx_state || state_d == await_wake_end_state)) begin
                rate_q <= neg_rate_q;
            end else if (state_q == fail_state && state_d == await_wake_end_state) begin
                rate_q <= `RATE_FASTEST;
            end
        end
    end

    // a word leaves the fifo only while staying in ready
    assign fifo_pop = fifo_valid && tx_ready && state_q == link_ready_state
                      && state_d == link_ready_state;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx.kind <= kind_quiet;
            tx.rate <= `RATE_FASTEST;
            tx.word <= `FILL_WORD;
        end else begin
            // rate settles while the line is quiet, so no ALIGN between rates
            tx.rate <= rate_q;
            case (state_d)
                wake_burst_tx_state: begin
                    tx.kind <= kind_wake;
                    tx.word <= `FILL_WORD;
                end
                align_tx_state: begin
                    tx.kind <= kind_align;
                    tx.word <= `ALIGN_WORD;
                end
                link_ready_state: begin
                    tx.kind <= fifo_pop ? kind_data : kind_fill;
                    tx.word <= fifo_pop ? fifo_data : `FILL_WORD;
                end
                default: begin
                    // sleep, rate change and fail are quiet lines
                    tx.kind <= kind_quiet;
                    tx.word <= `FILL_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phy_rdy <= 1'b0;
        end else begin
            phy_rdy <= (state_d == link_ready_state) && rx.sync;
        end
    end

    // register write side
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            ext_en_q <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_got_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_got_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (aw_got_q && w_got_q && !bvalid) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `RESP_OKAY;
                if (awaddr_q == `REG_CTRL_OFS) begin
                    if (wstrb_q[0]) begin
                        ext_en_q <= wdata_q[`CTRL_EXT_BIT];
                    end
                end else if (awaddr_q != `REG_STATUS_OFS) begin
                    bresp <= `RESP_SLVERR;
                end
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // register read side
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            if (araddr == `REG_CTRL_OFS) begin
                rdata <= {31'h00000000, ext_en_q};
            end else if (araddr == `REG_STATUS_OFS) begin
                rdata <= {17'h00000, resume_q, neg_rate_q, rate_q, phy_rdy, state_q};
            end else begin
                rdata <= '0;
                rresp <= `RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // helper: cycles spent sending ALIGN
    logic [15:0] align_age_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            align_age_q <= '0;
        end else if (state_q == align_tx_state) begin
            align_age_q <= align_age_q + 16'h0001;
        end else begin
            align_age_q <= '0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_power_fastest: assert property (
        state_q == listen_state |-> rate_q == `RATE_FASTEST)
        else $error("power-on rate is not the fastest");
    a_no_align_switch: assert property (
        state_q == reduce_speed_state && state_d == reduce_speed_state
        |=> tx.kind == kind_quiet)
        else $error("line active during rate change");
    a_wake_then_align: assert property (
        state_q == wake_burst_tx_state && state_d == align_tx_state
        |=> tx.kind == kind_align ##1 tx.kind != kind_quiet)
        else $error("idle gap after wake burst");
    a_xtalk_guard: assert property (
        state_q == align_tx_state && !guard_done |=> state_q != link_ready_state)
        else $error("ALIGN accepted in crosstalk window");
    a_align_bound: assert property (
        align_age_q <= 16'(ALIGN_WAIT_CYC + ALIGN_EXT_CYC))
        else $error("ALIGN wait exceeded the longest allowed");
    a_resume_rate: assert property (
        state_q == align_tx_state && resume_q |-> rate_q == neg_rate_q)
        else $error("resume not at negotiated rate");
    a_resume_retry: assert property (
        state_q == fail_state && resume_q
        |=> state_q == wake_burst_tx_state && $stable(rate_q))
        else $error("failed resume did not retry wake");
    a_ready_partial: assert property (
        state_q == link_ready_state && partial_req |=> state_q == light_sleep_state)
        else $error("partial request ignored");
    a_ready_slumber: assert property (
        state_q == link_ready_state && !partial_req && slumber_req
        |=> state_q == deep_sleep_state)
        else $error("slumber request ignored");
    a_ready_hold: assert property (
        state_q == link_ready_state && !partial_req && !slumber_req
        |=> state_q == link_ready_state)
        else $error("ready left without request");
    a_rdy_flag: assert property (
        phy_rdy |-> state_q == link_ready_state && $past(rx.sync))
        else $error("ready flag outside ready or sync");
    a_light_wake: assert property (
        state_q == light_sleep_state && !partial_req && !rx.comwake_det
        |=> state_q == wake_burst_tx_state ##1 tx.kind == kind_wake)
        else $error("light sleep exit did not wake");
    a_host_wins: assert property (
        state_q == light_sleep_state && !partial_req && rx.comwake_det
        |=> state_q == await_wake_end_state)
        else $error("host wake lost priority");

    c_reach_ready: cover property (state_q == align_tx_state ##1 state_q == link_ready_state);
    c_partial_wake: cover property (state_q == light_sleep_state ##1 state_q == wake_burst_tx_state);
    c_speed_drop: cover property (state_q == reduce_speed_state ##1 state_q == align_tx_state);
    c_word_sent: cover property (tx.kind == kind_data);
endmodule
`default_nettype wire

// [rtl/phy_ctl_consts.svh]
`ifndef PHY_CTL_CONSTS_SVH
`define PHY_CTL_CONSTS_SVH
`define CLK_NS 10
`define ALIGN_WAIT_NS 54600
`define ALIGN_EXT_NS 54600
`define XTALK_NS 533
`define WAKE_BURST_CYC 14'h0040
`define RATE_SETTLE_CYC 14'h0020
`define TMR_W 14
`define RATE_FASTEST 2'h1
`define RATE_LOWEST 2'h0
`define ALIGN_WORD 32'h7B4A4ABC
`define FILL_WORD 32'h00000000
`define WORD_W 32
`define FIFO_DEPTH 4
`define ADDR_W 8
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define CTRL_EXT_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [rtl/phy_ctl_pkg.sv]
package phy_ctl_pkg;
    typedef enum logic [8:0] {
        listen_state = 9'h001,
        await_wake_end_state = 9'h002,
        wake_burst_tx_state = 9'h004,
        align_tx_state = 9'h008,
        link_ready_state = 9'h010,
        light_sleep_state = 9'h020,
        deep_sleep_state = 9'h040,
        reduce_speed_state = 9'h080,
        fail_state = 9'h100
    } phy_state_e;
    typedef enum logic [2:0] {
        kind_quiet = 3'h0,
        kind_wake = 3'h1,
        kind_align = 3'h2,
        kind_data = 3'h3,
        kind_fill = 3'h4
    } tx_kind_e;
    typedef logic [1:0] rate_t;
    typedef struct packed {
        logic align_det;
        logic comwake_det;
        logic sync;
    } rx_status_s;
    typedef struct packed {
        tx_kind_e kind;
        rate_t rate;
        logic [31:0] word;
    } tx_out_s;
endpackage

// [rtl/cycle_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
    parameter int W = 14
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done
);
    logic [W-1:0] count_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    // done one cycle early so a load of n keeps the state for exactly n cycles
    assign done = (count_q <= W'(1));
endmodule
`default_nettype wire

// [rtl/word_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            // full and empty kept as flops so the ports are glitch free
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            in_ready <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
            out_valid <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != '0;
        end
    end
endmodule
`default_nettype wire

// [sim/host_phy_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_phy_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire phy_ctl_pkg::tx_out_s tx,
    input wire logic wake,
    input wire logic xtalk,
    input wire logic [7:0] ans_dly,
    input wire logic stall,
    output var phy_ctl_pkg::rx_status_s rx,
    output logic tx_ready
);
    import phy_ctl_pkg::*;
    logic [7:0] n_q;
    logic ans;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            n_q <= 8'h00;
        end else if (tx.kind == kind_align) begin
            n_q <= (n_q == 8'hFF) ? n_q : n_q + 8'h01;
        end else begin
            n_q <= 8'h00;
        end
    end
    // zero delay means a host that never answers
    assign ans = (ans_dly != 8'h00) && (n_q >= ans_dly);
    // one-cycle glitch early in the idle window mimics crosstalk
    assign rx = {ans || (xtalk && n_q == 8'h05), wake, ans || tx.kind == kind_fill
        || tx.kind == kind_data};
    assign tx_ready = !stall;
endmodule
`default_nettype wire

// [sim/sata_device_phy_align_ready_partial_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sata_device_phy_align_ready_partial_tb_top;
    import phy_ctl_pkg::*;
    typedef struct packed {logic [31:0] w; tx_kind_e k;} row_s;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    tx_out_s tx;
    rx_status_s rx;
    logic tx_ready, word_ready, phy_rdy, awready, wready, bvalid, arready, rvalid;
    logic partial_req = 1'b0, slumber_req = 1'b0, word_valid = 1'b0;
    logic wake = 1'b0, xtalk = 1'b0, stall = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] ans_dly = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] word_data = 32'h0, wdata = 32'h0, rdata, s;
    logic [1:0] bresp, rresp, r;
    int mismatches = 0, compares = 0, cyc = 0, n;
    row_s rows [4] = '{'{32'h00000000, kind_data}, '{32'hFFFFFFFF, kind_data},
        '{32'h7B4A4ABC, kind_data}, '{32'hA5A5A5A5, kind_data}};
    phy_ctl #(.ALIGN_WAIT_CYC(100), .ALIGN_EXT_CYC(100)) phy_ctl_inst (
        .mclk(mclk), .rstn(rstn), .rx(rx), .tx_ready(tx_ready), .tx(tx),
        .partial_req(partial_req), .slumber_req(slumber_req), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data), .phy_rdy(phy_rdy),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    host_phy_model host_phy_model_inst (.mclk(mclk), .rstn(rstn), .tx(tx), .wake(wake),
        .xtalk(xtalk), .ans_dly(ans_dly), .stall(stall), .rx(rx), .tx_ready(tx_ready));
    always #5 mclk = ~mclk;
    task automatic results();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, generous over the roughly 1300 cycles needed
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ck_kind(input tx_kind_e e);
        chk(32'(tx.kind), 32'(e));
    endtask
    task automatic wait_kind(input tx_kind_e e);
        n = 0;
        while (tx.kind !== e && n < 400) begin
            @(posedge mclk);
            n++;
        end
        ck_kind(e);
    endtask
    task automatic span(input tx_kind_e e);
        n = 0;
        while (tx.kind === e) begin
            @(posedge mclk);
            n++;
        end
    endtask
    // one task for both directions keeps the handshake logic in one place
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic aw, w, ar, b;
        aw = wr;
        w = wr;
        ar = !wr;
        b = 1'b1;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        arvalid <= !wr;
        bready <= wr;
        rready <= !wr;
        while (b) begin
            @(posedge mclk);
            if (!aw && !w && !ar && (bvalid || rvalid)) begin
                b = 1'b0;
                r = wr ? bresp : rresp;
                s = rdata;
                bready <= 1'b0;
                rready <= 1'b0;
            end
            aw = aw && !awready;
            w = w && !wready;
            ar = ar && !arready;
            awvalid <= aw;
            wvalid <= w;
            arvalid <= ar;
        end
        @(posedge mclk);
    endtask
    task automatic push(input logic [31:0] d);
        word_data <= d;
        word_valid <= 1'b1;
        @(posedge mclk);
        while (!word_ready) @(posedge mclk);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        chk(32'({tx.kind, tx.rate, phy_rdy, word_ready, awready, wready, arready, bvalid, rvalid}),
            32'h0BC);
        rstn <= 1'b1;
        @(posedge mclk);
        axi(1'b0, 8'h00, 32'h0);
        chk(s, 32'h0);
        axi(1'b0, 8'h08, 32'h0);
        chk({30'h0, r}, 32'h2);
        chk(s, 32'h0);
        axi(1'b1, 8'h0C, 32'h1);
        chk({30'h0, r}, 32'h2);
        axi(1'b1, 8'h04, 32'h1);
        chk({30'h0, r}, 32'h0);
        xtalk <= 1'b1;
        ans_dly <= 8'h50;
        wake <= 1'b1;
        repeat (4) @(posedge mclk);
        wake <= 1'b0;
        wait_kind(kind_wake);
        span(kind_wake);
        chk(n, 64);
        ck_kind(kind_align);
        chk(32'(tx.rate), 32'h1);
        span(kind_align);
        chk(32'(n > 60), 32'h1);
        wait_kind(kind_fill);
        @(posedge mclk);
        chk(32'(phy_rdy), 32'h1);
        axi(1'b0, 8'h04, 32'h0);
        chk(32'(s[13:0]), 32'h1610);
        foreach (rows[i]) begin
            push(rows[i].w);
            word_valid <= 1'b0;
            wait_kind(rows[i].k);
            chk(tx.word, rows[i].w);
        end
        stall <= 1'b1;
        for (int i = 0; i < 4; i++) push(32'h1000 + 32'(i));
        word_valid <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(32'(word_ready), 32'h0);
        ck_kind(kind_fill);
        stall <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wait_kind(kind_data);
            chk(tx.word, 32'h1000 + 32'(i));
            @(posedge mclk);
        end
        partial_req <= 1'b1;
        repeat (2) @(posedge mclk);
        ck_kind(kind_quiet);
        chk(32'(phy_rdy), 32'h0);
        axi(1'b0, 8'h04, 32'h0);
        chk(32'(s[8:0]), 32'h20);
        partial_req <= 1'b0;
        wake <= 1'b1;
        repeat (2) @(posedge mclk);
        axi(1'b0, 8'h04, 32'h0);
        chk(32'(s[8:0]), 32'h2);
        wake <= 1'b0;
        wait_kind(kind_align);
        chk(32'(tx.rate), 32'h1);
        wait_kind(kind_fill);
        axi(1'b1, 8'h00, 32'h1);
        ans_dly <= 8'h00;
        slumber_req <= 1'b1;
        repeat (2) @(posedge mclk);
        axi(1'b0, 8'h04, 32'h0);
        chk(32'(s[8:0]), 32'h40);
        slumber_req <= 1'b0;
        wait_kind(kind_wake);
        wait_kind(kind_align);
        chk(32'(tx.rate), 32'h1);
        span(kind_align);
        chk(32'(n > 195 && n < 205), 32'h1);
        wait_kind(kind_wake);
        chk(32'(tx.rate), 32'h1);
        ans_dly <= 8'h50;
        wait_kind(kind_fill);
        rstn <= 1'b0;
        ans_dly <= 8'h00;
        repeat (2) @(posedge mclk);
        chk(32'({tx.kind, phy_rdy}), 32'h0);
        rstn <= 1'b1;
        wake <= 1'b1;
        repeat (4) @(posedge mclk);
        wake <= 1'b0;
        wait_kind(kind_align);
        span(kind_align);
        chk(n, 100);
        ck_kind(kind_quiet);
        wait_kind(kind_align);
        chk(32'(tx.rate), 32'h0);
        span(kind_align);
        ck_kind(kind_quiet);
        ans_dly <= 8'h50;
        wake <= 1'b1;
        repeat (2) @(posedge mclk);
        wake <= 1'b0;
        wait_kind(kind_align);
        chk(32'(tx.rate), 32'h1);
        wait_kind(kind_fill);
        results();
    end
endmodule
`default_nettype wire
